/* rtl/bidsr_top.sv */
// Bridge identity and status register with device number and strap capture
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Function field bits 2:0 holds function number from AD 10:8; resets zero.
// - Qualifying config write loads device field bits 7:3 from AD 15:11.
// - Device capture happens for any register offset the write selects.
// - Qualify: config write command, IDSEL, AD 1:0 zero, AD 10:8 matches function.
// - Device field resets to all ones until first qualifying write.
// - Bus field bits 15:8 mirrors primary bus number register; resets to ones.
// - Completer ID for internal register reads built from bus, device, function.
// - Same identity fields used when interfaces mix conventional and PCI-X modes.
// - Bit 16 shows primary 64-bit capability, only with wide bus strap high.
// - Bit 16 is zero in forward mode, or reverse with REQ64 high.
// - Reverse mode with REQ64 low and wide bus strap high, sampled once the settle count ends after reset release, sets bit 16.
module bidsr_top (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic cfg_addr_phase_i,
    input wire logic [3:0] cfg_cmd_i,
    input wire logic idsel_i,
    input wire logic [31:0] cfg_ad_i,
    input wire logic [7:0] prim_bus_num_i,
    input wire logic reverse_mode_i,
    input wire logic wide_bus_strap_i,
    input wire logic req64_n_i,
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_ack_o,
    output logic [15:0] completer_id_o,
    output logic wide_capable_o,
    output logic strap_done_o
);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic targets_bridge(input logic [3:0] cmd, input logic sel,
                                            input logic [31:0] ad, input logic [2:0] func);
        targets_bridge = (cmd == bidsr_pkg::CMD_CFG_WRITE) && sel &&
                         (ad[1:0] == bidsr_pkg::AD_TYPE0) &&
                         (ad[bidsr_pkg::AD_FUNC_MSB:bidsr_pkg::AD_FUNC_LSB] == func);
    endfunction

    function automatic logic [31:0] pack_status(input logic [7:0] bus, input logic [4:0] dev,
                                                input logic [2:0] func, input logic wide);
        pack_status = {15'h0000, wide, bus, dev, func};
    endfunction

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [2:0] rev_sync;
    logic [2:0] wide_sync;
    logic [2:0] req64_sync;
    logic [2:0] next_rev_sync;
    logic [2:0] next_wide_sync;
    logic [2:0] next_req64_sync;

    always_comb begin
        next_rev_sync = {rev_sync[1:0], reverse_mode_i};
        next_wide_sync = {wide_sync[1:0], wide_bus_strap_i};
        next_req64_sync = {req64_sync[1:0], req64_n_i};
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rev_sync <= 3'h0;
            wide_sync <= 3'h0;
            req64_sync <= 3'h7;
        end else begin
            rev_sync <= next_rev_sync;
            wide_sync <= next_wide_sync;
            req64_sync <= next_req64_sync;
        end
    end

    logic pins_agree;
    assign pins_agree = (rev_sync[1] == rev_sync[2]) && (wide_sync[1] == wide_sync[2]) &&
                        (req64_sync[1] == req64_sync[2]);

    // ----------------------------------------
    // Strap capture after reset release
    // ----------------------------------------
    bidsr_pkg::bidsr_state_type state;
    bidsr_pkg::bidsr_state_type next_state;
    logic [1:0] settle_cnt;
    logic [1:0] next_settle_cnt;
    logic wide_cap;
    logic next_wide_cap;

    always_comb begin
        next_state = state;
        next_settle_cnt = settle_cnt;
        next_wide_cap = wide_cap;
        unique case (state)
            bidsr_pkg::BIDSR_SETTLE: begin
                next_settle_cnt = settle_cnt + 2'h1;
                if (settle_cnt == bidsr_pkg::SYNC_SETTLE) begin
                    next_state = bidsr_pkg::BIDSR_SAMPLE;
                end
            end
            bidsr_pkg::BIDSR_SAMPLE: begin
                if (pins_agree) begin
                    // Reverse mode, REQ64 low and strap high give a 64-bit primary
                    next_wide_cap = rev_sync[2] && !req64_sync[2] && wide_sync[2];
                    next_state = bidsr_pkg::BIDSR_DONE;
                end
            end
            bidsr_pkg::BIDSR_DONE: begin
                next_state = bidsr_pkg::BIDSR_DONE;
            end
            default: begin
                next_state = bidsr_pkg::BIDSR_SETTLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= bidsr_pkg::BIDSR_SETTLE;
            settle_cnt <= 2'h0;
            wide_cap <= bidsr_pkg::WIDE_RESET;
        end else begin
            state <= next_state;
            settle_cnt <= next_settle_cnt;
            wide_cap <= next_wide_cap;
        end
    end

    // ----------------------------------------
    // Identity fields
    // ----------------------------------------
    logic [2:0] func_num;
    logic [4:0] dev_num;
    logic [7:0] bus_num;
    logic [2:0] next_func_num;
    logic [4:0] next_dev_num;
    logic [7:0] next_bus_num;
    logic cfg_hit;

    assign cfg_hit = cfg_addr_phase_i && targets_bridge(cfg_cmd_i, idsel_i, cfg_ad_i, func_num);

    always_comb begin
        next_func_num = func_num;
        next_dev_num = dev_num;
        next_bus_num = prim_bus_num_i;
        // Offset bits play no part in the hit
        if (cfg_hit) begin
            next_dev_num = cfg_ad_i[bidsr_pkg::AD_DEV_MSB:bidsr_pkg::AD_DEV_LSB];
            next_func_num = cfg_ad_i[bidsr_pkg::AD_FUNC_MSB:bidsr_pkg::AD_FUNC_LSB];
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            func_num <= bidsr_pkg::FUNC_RESET;
            dev_num <= bidsr_pkg::DEV_RESET;
            bus_num <= bidsr_pkg::BUS_RESET;
        end else begin
            func_num <= next_func_num;
            dev_num <= next_dev_num;
            bus_num <= next_bus_num;
        end
    end

    // ----------------------------------------
    // Register port and outputs
    // ----------------------------------------
    logic [31:0] next_rdata;
    logic next_ack;
    logic [15:0] next_cid;

    always_comb begin
        next_rdata = 32'h0000_0000;
        next_ack = reg_rd_i || reg_wr_i;
        // Writes are acknowledged and dropped; every field is read-only
        if (reg_rd_i && (reg_addr_i == bidsr_pkg::IDENT_STATUS_OFFSET)) begin
            next_rdata = pack_status(bus_num, dev_num, func_num, wide_cap);
        end
        next_cid = {bus_num, dev_num, func_num};
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 32'h0000_0000;
            reg_ack_o <= 1'b0;
            completer_id_o <= {bidsr_pkg::BUS_RESET, bidsr_pkg::DEV_RESET, bidsr_pkg::FUNC_RESET};
            wide_capable_o <= bidsr_pkg::WIDE_RESET;
            strap_done_o <= 1'b0;
        end else begin
            reg_rdata_o <= next_rdata;
            reg_ack_o <= next_ack;
            completer_id_o <= next_cid;
            wide_capable_o <= wide_cap;
            strap_done_o <= (state == bidsr_pkg::BIDSR_DONE);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);

    dev_capture_a: assert property (nrst_i && cfg_hit |=> dev_num == $past(cfg_ad_i[15:11]))
        else $error("device number not captured");
    dev_hold_a: assert property (!cfg_hit |=> $stable(dev_num))
        else $error("device number changed without a hit");
    hit_qualify_a: assert property (cfg_hit |-> cfg_cmd_i == 4'hb && idsel_i && cfg_ad_i[1:0] == 2'h0 &&
                                    cfg_ad_i[10:8] == func_num)
        else $error("write hit without all qualifiers");
    func_stable_a: assert property ($stable(func_num))
        else $error("function number moved");
    bus_follow_a: assert property (nrst_i |=> bus_num == $past(prim_bus_num_i))
        else $error("bus number not following header");
    cid_build_a: assert property (nrst_i |=> completer_id_o == {$past(bus_num), $past(dev_num), $past(func_num)})
        else $error("completer id mismatch");
    wide_strap_a: assert property (state == bidsr_pkg::BIDSR_SAMPLE && pins_agree &&
                                   !(wide_sync[2] && rev_sync[2]) |=> !wide_cap)
        else $error("wide flag without strap or reverse mode");
    wide_zero_a: assert property (state != bidsr_pkg::BIDSR_DONE |-> !wide_cap)
        else $error("wide flag set before capture");
    wide_set_a: assert property (state == bidsr_pkg::BIDSR_SAMPLE && pins_agree && rev_sync[2] &&
                                 !req64_sync[2] && wide_sync[2] |=> wide_cap ##1 wide_capable_o)
        else $error("wide flag not set in reverse mode");
    rd_data_a: assert property (nrst_i && reg_rd_i && reg_addr_i == bidsr_pkg::IDENT_STATUS_OFFSET |=>
                                reg_ack_o && reg_rdata_o[15:0] == {$past(bus_num), $past(dev_num), $past(func_num)})
        else $error("register read data wrong");
    wr_ignore_a: assert property (reg_wr_i && !cfg_hit && state == bidsr_pkg::BIDSR_DONE |=>
                                  $stable(dev_num) && $stable(wide_cap))
        else $error("software write changed a field");
    done_bound_a: assert property ($rose(nrst_i) |-> ##[1:40] strap_done_o)
        else $error("strap capture too slow");

    hit_c: cover property (cfg_hit ##1 dev_num != 5'h1f);
    wide_c: cover property ($rose(wide_capable_o));
    read_c: cover property (reg_rd_i && reg_addr_i == 8'h84);
    write_c: cover property (reg_wr_i && reg_addr_i == 8'h84);

endmodule

`default_nettype wire

/* rtl/bidsr_pkg.sv */
// Constants for the bridge identity and status register
package bidsr_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [7:0] IDENT_STATUS_OFFSET = 8'h84;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int FUNC_LSB = 0;
    localparam int FUNC_MSB = 2;
    localparam int DEV_LSB = 3;
    localparam int DEV_MSB = 7;
    localparam int BUS_LSB = 8;
    localparam int BUS_MSB = 15;
    localparam int WIDE_BIT = 16;

    // ----------------------------------------
    // Address phase decode
    // ----------------------------------------
    localparam int AD_FUNC_LSB = 8;
    localparam int AD_FUNC_MSB = 10;
    localparam int AD_DEV_LSB = 11;
    localparam int AD_DEV_MSB = 15;
    localparam logic [1:0] AD_TYPE0 = 2'h0;
    localparam logic [3:0] CMD_CFG_WRITE = 4'hb;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [2:0] FUNC_RESET = 3'h0;
    localparam logic [4:0] DEV_RESET = 5'h1f;
    localparam logic [7:0] BUS_RESET = 8'hff;
    localparam logic WIDE_RESET = 1'b0;

    // ----------------------------------------
    // Strap capture timing
    // ----------------------------------------
    localparam logic [1:0] SYNC_SETTLE = 2'h3;

    typedef enum logic [1:0] {
        BIDSR_SETTLE = 2'b00,
        BIDSR_SAMPLE = 2'b01,
        BIDSR_DONE = 2'b11
    } bidsr_state_type;

endpackage

/* tb/bidsr_host_model.sv */
// Host model: primary config address phases and reset-time pins
`timescale 1ns/1ps
`default_nettype none
module bidsr_host_model (
    input wire logic sys_clk_i,
    output logic cfg_addr_phase_o,
    output logic [3:0] cfg_cmd_o,
    output logic idsel_o,
    output logic [31:0] cfg_ad_o,
    output logic reverse_mode_o,
    output logic wide_bus_strap_o,
    output logic req64_n_o
);
    initial begin
        cfg_addr_phase_o = 1'b0;
        cfg_cmd_o = 4'h0;
        idsel_o = 1'b0;
        cfg_ad_o = 32'h5a5a5a5a;
        reverse_mode_o = 1'b0;
        wide_bus_strap_o = 1'b0;
        req64_n_o = 1'b1;
    end
    // One address phase; lines then show the inverse, not a held value
    task automatic cfg_cycle(input logic [3:0] cmd, input logic sel, input logic [31:0] ad);
        @(posedge sys_clk_i);
        cfg_addr_phase_o <= 1'b1;
        cfg_cmd_o <= cmd;
        idsel_o <= sel;
        cfg_ad_o <= ad;
        @(posedge sys_clk_i);
        cfg_addr_phase_o <= 1'b0;
        cfg_cmd_o <= ~cmd;
        idsel_o <= ~sel;
        cfg_ad_o <= ~ad;
    endtask
    // Pins held steady across reset release until the next call
    task automatic set_pins(input logic rev, input logic strap, input logic req_n);
        reverse_mode_o <= rev;
        wide_bus_strap_o <= strap;
        req64_n_o <= req_n;
    endtask
endmodule
`default_nettype wire

/* tb/bridge_id_status_register_bench.sv */
// Self-checking bench for the identity and status register
`timescale 1ns/1ps
`default_nettype none
module bridge_id_status_register_bench;
    logic sys_clk_i, nrst_i, reg_rd_i, reg_wr_i;
    logic [7:0] reg_addr_i, prim_bus_num_i, exp_bus;
    logic [31:0] reg_wdata_i, reg_rdata_o, lfsr, ad;
    logic [15:0] completer_id_o;
    logic reg_ack_o, wide_capable_o, strap_done_o, exp_wide;
    logic cfg_addr_phase_i, idsel_i, reverse_mode_i, wide_bus_strap_i, req64_n_i;
    logic [3:0] cfg_cmd_i;
    logic [31:0] cfg_ad_i;
    logic [4:0] exp_dev;
    logic [31:0] exp_q[$];
    int fails, n_tests, cycles;
    localparam logic [7:0] OFS = bidsr_pkg::IDENT_STATUS_OFFSET;

    bidsr_host_model bidsr_host_model_i (.sys_clk_i(sys_clk_i), .cfg_addr_phase_o(cfg_addr_phase_i),
        .cfg_cmd_o(cfg_cmd_i), .idsel_o(idsel_i), .cfg_ad_o(cfg_ad_i), .reverse_mode_o(reverse_mode_i),
        .wide_bus_strap_o(wide_bus_strap_i), .req64_n_o(req64_n_i));
    bidsr_top bidsr_top_i (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .cfg_addr_phase_i(cfg_addr_phase_i),
        .cfg_cmd_i(cfg_cmd_i), .idsel_i(idsel_i), .cfg_ad_i(cfg_ad_i), .prim_bus_num_i(prim_bus_num_i),
        .reverse_mode_i(reverse_mode_i), .wide_bus_strap_i(wide_bus_strap_i), .req64_n_i(req64_n_i),
        .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o), .completer_id_o(completer_id_o),
        .wide_capable_o(wide_capable_o), .strap_done_o(strap_done_o));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] status();
        return {15'h0, exp_wide, exp_bus, exp_dev, 3'h0};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s got %h want %h", $time, msg, got, exp);
        end
    endtask
    task automatic reg_op(input logic rd, input logic [7:0] addr, input logic [31:0] exp);
        lfsr = next_rand(lfsr);
        @(posedge sys_clk_i);
        reg_rd_i <= rd;
        reg_wr_i <= !rd;
        reg_addr_i <= addr;
        reg_wdata_i <= lfsr;
        exp_q.push_back(exp);
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        reg_wr_i <= 1'b0;
    endtask
    task automatic do_reset(input logic rev, input logic strap, input logic req_n);
        int i;
        bidsr_host_model_i.set_pins(rev, strap, req_n);
        @(posedge sys_clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        exp_dev = 5'h1f;
        exp_wide = rev & strap & !req_n;
        for (i = 0; i < 20 && strap_done_o !== 1'b1; i++) @(negedge sys_clk_i);
        repeat (2) @(negedge sys_clk_i);
        check({31'h0, wide_capable_o}, {31'h0, exp_wide}, "wide flag");
        check({31'h0, strap_done_o}, 32'h1, "strap done");
        check({16'h0, completer_id_o}, {16'h0, exp_bus, exp_dev, 3'h0}, "reset id");
    endtask
    task automatic report_and_stop();
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Every acknowledge retires the oldest expected word
    always @(negedge sys_clk_i) begin
        if (reg_ack_o === 1'b1) begin
            if (exp_q.size() == 0) check(32'h1, 32'h0, "unexpected ack");
            else check(reg_rdata_o, exp_q.pop_front(), "read data");
        end
    end
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles > 2000) begin
            fails++;
            report_and_stop();
        end
    end
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        nrst_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_addr_i = 8'h00;
        reg_wdata_i = 32'h0;
        prim_bus_num_i = 8'hff;
        exp_bus = 8'hff;
        lfsr = 32'h0001146b;
        for (int m = 0; m < 8; m++) begin
            do_reset(m[2], m[1], m[0]);
            reg_op(1'b1, OFS, status());
        end
        lfsr = next_rand(lfsr);
        @(posedge sys_clk_i);
        prim_bus_num_i <= lfsr[7:0];
        exp_bus = lfsr[7:0];
        reg_op(1'b0, OFS, 32'h0);
        reg_op(1'b1, 8'h80, 32'h0);
        reg_op(1'b1, OFS, status());
        for (int k = 0; k < 6; k++) begin
            lfsr = next_rand(lfsr);
            ad = lfsr;
            ad[10:8] = (k == 4) ? 3'h1 : 3'h0;
            ad[1:0] = (k == 3) ? 2'h1 : 2'h0;
            bidsr_host_model_i.cfg_cycle((k == 1) ? 4'ha : bidsr_pkg::CMD_CFG_WRITE, k != 2, ad);
            if (k == 0 || k == 5) exp_dev = ad[15:11];
            repeat (2) @(negedge sys_clk_i);
            check({16'h0, completer_id_o}, {16'h0, exp_bus, exp_dev, 3'h0}, "completer id");
            reg_op(1'b1, OFS, status());
        end
        do_reset(1'b0, 1'b1, 1'b0);
        reg_op(1'b1, OFS, status());
        repeat (3) @(negedge sys_clk_i);
        check(exp_q.size(), 32'h0, "missing acks");
        report_and_stop();
    end
endmodule
`default_nettype wire
